// ===== src/utts_pkg.sv
// Shared constants and types of the underreach transfer trip logic.
// Assumes a single 100 MHz clock and an APB master on the register side.
package utts_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int          CLK_MHZ              = 100;
  localparam int          DIG_TIMEOUT_US       = 10;
  localparam logic [15:0] DIG_TIMEOUT_CYC      = 16'(DIG_TIMEOUT_US * CLK_MHZ);
  localparam int          PROLONG_W            = 32;
  localparam longint      PROLONG_RST_MS       = 50;
  localparam longint      PROLONG_RST_CYC      = PROLONG_RST_MS * 1000 * CLK_MHZ;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam int          ADDR_W               = 8;
  localparam logic [7:0]  ADDR_SWCMD           = 8'h00;
  localparam logic [7:0]  ADDR_CFG             = 8'h04;
  localparam logic [7:0]  ADDR_PROLONG         = 8'h08;
  localparam logic [7:0]  ADDR_STATUS          = 8'h0c;

  // Switch command bits, write one to request.
  localparam int          SW_SET_ON_BIT        = 0;
  localparam int          SW_SET_OFF_BIT       = 1;
  localparam int          SW_SYS_ON_BIT        = 2;
  localparam int          SW_SYS_OFF_BIT       = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Switching sources; the code of source i is i + 1.
  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_SETTING = 2'b01,
    SRC_SYSIF   = 2'b10,
    SRC_BINARY  = 2'b11
  } utts_src_t;

  // Configuration word, bit 0 upward: mode, line_terminal_setting,
  // digital_interface_signalling, reserved, relay_count_setting, segregation,
  // underreach_direction_setting, overreach_direction_setting, block on disturbance.
  typedef struct packed {
    logic       block_en;
    logic       oz_fwd;
    logic       uz_fwd;
    logic       seg;
    logic [1:0] relay_count;
    logic       rsvd;
    logic       digital;
    logic       three_term;
    logic       mode_oz;
  } utts_cfg_t;

  localparam utts_cfg_t   CFG_RST              = 10'h3a0;

  // Switched state kept in retained storage outside the block.
  typedef struct packed {
    utts_src_t  last_off;
    logic [2:0] src_on;
  } utts_nv_t;

  localparam utts_nv_t    NV_RST               = 5'h07;

  typedef struct packed {
    utts_cfg_t                  cfg;
    logic [PROLONG_W-1:0]       prolong;
    utts_nv_t                   nv;
    logic                       bin_q;
    logic                       restored;
    logic [2:0][PROLONG_W-1:0]  cnt;
    logic [15:0]                dig_cnt;
    logic                       disturbed;
    logic                       active;
    logic [2:0]                 tx_a;
    logic [2:0]                 tx_b;
    logic [2:0]                 trip;
    logic                       oz_enable;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } utts_state_t;

endpackage

// ===== src/utts_core.sv
// Teleprotection send and receive logic for permissive underreach schemes.
// Assumes inputs synchronous to pclk and a retained store for the switch state.
//
// How it works
// R1 - Active only when all three sources on.
// R2 - Switch on only from last off source.
// R3 - Switch state mirrored to retained storage.
// R4 - Pickup mode: send on underreach zone fault.
// R5 - Pickup mode: receive trips only when picked up.
// R6 - Send held for prolongation time afterwards.
// R7 - Pickup mode ignores the overreach zone.
// R8 - Send, and overreach mode trip, only for forward faults.
// R9 - Two-terminal segregation gives per-phase circuits.
// R10 - Three-terminal: send both ends, OR receives.
// R11 - Conventional: line setting picks remote count.
// R12 - Overreach mode: trip needs overreach forward fault.
// R13 - Digital: relay count 3 means two remotes.
// R14 - Digital interface always phase segregated.
// R15 - Conventional three-terminal never phase segregated.
// R16 - Disturbance may block the supplement only.
// R17 - Disturbance from input, or detected when digital.
// R18 - Disturbed link: reclose release enables overreach.
// R19 - Far end provides a channel per direction.
// R20 - Prolongation is a reloaded clock down-counter.
// R21 - Inputs sampled each cycle, outputs registered.
//
// Chosen here: register access over APB and the placing of the registers.
module utts_core
  import utts_pkg::*;
#(
  parameter longint PROLONG_DEFAULT_CYC = PROLONG_RST_CYC
) (
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic              bin_switch,
  input  logic              nv_valid,
  input  utts_nv_t          nv_in,
  output utts_nv_t          nv_out,
  input  logic [2:0]        underreach_zone,
  input  logic [2:0]        overreach_zone,
  input  logic [2:0]        pickup,
  input  logic              fault_forward,
  input  logic [2:0]        rx_a,
  input  logic [2:0]        rx_b,
  input  logic              chan_fail,
  input  logic              dig_frame_ok,
  input  logic              reclose_zone_release_input,
  output logic [2:0]        tx_a,
  output logic [2:0]        tx_b,
  output logic [2:0]        trip,
  output logic              overreach_zone_enable,
  output logic              chan_disturbed,
  output logic              teleprot_active
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check and reset value.
  if (PROLONG_DEFAULT_CYC < 0 || PROLONG_DEFAULT_CYC >= (64'd1 << PROLONG_W)) begin : g_chk
    $error("PROLONG_DEFAULT_CYC does not fit the prolongation counter.");
  end

  localparam utts_state_t STATE_RST = '{
    cfg:       CFG_RST,
    prolong:   PROLONG_W'(PROLONG_DEFAULT_CYC),
    nv:        NV_RST,
    bin_q:     1'b1,
    default:   '0
  };

  utts_state_t s_r;
  utts_state_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic                 setup;
    logic                 access;
    logic                 mapped;
    logic [2:0]           on_req;
    logic [2:0]           off_req;
    logic                 two_remote;
    logic                 segregated;
    logic                 blocked;
    logic [2:0]           send;
    logic [2:0]           tx;
    logic [2:0]           rx;
    logic [2:0]           permit;
    utts_src_t            code;
    setup      = 1'b0;
    access     = 1'b0;
    mapped     = 1'b0;
    on_req     = '0;
    off_req    = '0;
    two_remote = 1'b0;
    segregated = 1'b0;
    blocked    = 1'b0;
    send       = '0;
    tx         = '0;
    rx         = '0;
    permit     = '0;
    code       = SRC_NONE;
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;

    // Bus slave: no wait states, answer in the first access cycle.
    setup  = psel && !penable && !s_r.pready;
    access = psel && penable && s_r.pready;
    mapped = (paddr == ADDR_SWCMD) || (paddr == ADDR_CFG) ||
             (paddr == ADDR_PROLONG) || (paddr == ADDR_STATUS);
    if (setup) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !mapped;
      s_nxt.prdata  = '0;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_CFG:     s_nxt.prdata = {22'h0, s_r.cfg};
          ADDR_PROLONG: s_nxt.prdata = s_r.prolong;
          ADDR_STATUS:  s_nxt.prdata = {15'h0, s_r.trip, s_r.tx_b, s_r.tx_a, s_r.oz_enable,
                                        s_r.disturbed, s_r.nv.last_off, s_r.nv.src_on,
                                        s_r.active};
          default:      s_nxt.prdata = '0;
        endcase
      end
    end
    if (access && pwrite) begin
      unique case (paddr)
        ADDR_SWCMD: begin
          on_req[0]  = pwdata[SW_SET_ON_BIT];
          off_req[0] = pwdata[SW_SET_OFF_BIT];
          on_req[1]  = pwdata[SW_SYS_ON_BIT];
          off_req[1] = pwdata[SW_SYS_OFF_BIT];
        end
        ADDR_CFG: begin
          s_nxt.cfg      = utts_cfg_t'(pwdata[9:0]);
          s_nxt.cfg.rsvd = 1'b0;
        end
        ADDR_PROLONG: s_nxt.prolong = pwdata;
        default: ;
      endcase
    end

    // On/off switching from setting, system interface and binary input.
    if (!s_r.restored) begin
      s_nxt.restored = 1'b1;
      s_nxt.bin_q    = bin_switch;
      if (nv_valid) begin
        s_nxt.nv = nv_in; // R3
      end
    end else begin
      s_nxt.bin_q = bin_switch;
      on_req[2]   = bin_switch && !s_r.bin_q;
      off_req[2]  = !bin_switch && s_r.bin_q;
      for (int i = 0; i < 3; i++) begin
        code = utts_src_t'(2'(i + 1));
        if (off_req[i]) begin
          s_nxt.nv.src_on[i] = 1'b0;
          s_nxt.nv.last_off  = code;
        end else if (on_req[i] && s_r.nv.last_off == code) begin
          s_nxt.nv.src_on[i] = 1'b1; // R2
        end
      end
    end
    s_nxt.active = &s_r.nv.src_on; // R1

    // Channel supervision.
    if (dig_frame_ok) begin
      s_nxt.dig_cnt = '0;
    end else if (s_r.dig_cnt != DIG_TIMEOUT_CYC) begin
      s_nxt.dig_cnt = s_r.dig_cnt + 16'h0001;
    end
    s_nxt.disturbed = s_r.cfg.digital ? (s_r.dig_cnt == DIG_TIMEOUT_CYC) : chan_fail; // R17
    blocked = s_r.disturbed && s_r.cfg.block_en; // R16
    s_nxt.oz_enable = s_r.disturbed && reclose_zone_release_input; // R18

    // Line configuration.
    two_remote = s_r.cfg.digital ? (s_r.cfg.relay_count == 2'd3) // R13
                                 : s_r.cfg.three_term; // R11
    segregated = s_r.cfg.digital || (s_r.cfg.seg && !s_r.cfg.three_term); // R14 R15 R9

    // Send with prolongation, per phase.
    for (int p = 0; p < 3; p++) begin
      send[p] = underreach_zone[p] && fault_forward && s_r.cfg.uz_fwd &&
                s_r.active && !blocked; // R4 R8
      if (send[p]) begin
        s_nxt.cnt[p] = s_r.prolong; // R20
      end else if (s_r.cnt[p] != '0) begin
        s_nxt.cnt[p] = s_r.cnt[p] - PROLONG_W'(1);
      end
      // A running stretch must not outlive a block or a switch-off.
      send[p] = (send[p] || (s_r.cnt[p] != '0)) && s_r.active && !blocked; // R6 R16
    end
    tx = segregated ? send : {3{|send}};
    s_nxt.tx_a = tx; // R21
    s_nxt.tx_b = two_remote ? tx : 3'h0; // R10

    // Receive and trip.
    rx = two_remote ? (rx_a | rx_b) : rx_a; // R10
    rx = segregated ? rx : {3{|rx}};
    if (s_r.cfg.mode_oz) begin
      permit = overreach_zone & {3{fault_forward && s_r.cfg.oz_fwd}}; // R12 R8
    end else begin
      permit = pickup; // R5 R7
    end
    permit = segregated ? permit : {3{|permit}}; // R9
    s_nxt.trip = rx & permit & {3{s_r.active && !blocked}}; // R21
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register. The retained copy is restored after reset by a clocked
  // load, because an asynchronous reset may only load constants.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata                = s_r.prdata;
  assign pready                = s_r.pready;
  assign pslverr               = s_r.pslverr;
  assign nv_out                = s_r.nv;
  assign tx_a                  = s_r.tx_a;
  assign tx_b                  = s_r.tx_b;
  assign trip                  = s_r.trip;
  assign overreach_zone_enable = s_r.oz_enable;
  assign chan_disturbed        = s_r.disturbed;
  assign teleprot_active       = s_r.active;

endmodule

// ===== tb/utts_properties.sv
// Port checker for the underreach transfer trip logic.
// Assumes binding to utts_core with the same prolongation parameter.
module utts_properties
  import utts_pkg::*;
#(parameter longint PROLONG_DEFAULT_CYC = PROLONG_RST_CYC) (
  input logic       pclk,
  input logic       presetn,
  input utts_nv_t   nv_out,
  input logic [2:0] underreach_zone,
  input logic [2:0] overreach_zone,
  input logic [2:0] pickup,
  input logic       fault_forward,
  input logic [2:0] rx_a,
  input logic [2:0] rx_b,
  input logic       chan_fail,
  input logic       dig_frame_ok,
  input logic       reclose_zone_release_input,
  input logic [2:0] tx_a,
  input logic [2:0] tx_b,
  input logic [2:0] trip,
  input logic       overreach_zone_enable,
  input logic       chan_disturbed,
  input logic       teleprot_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both counters saturate so a long quiet spell never wraps into a false match.
  logic [15:0] idle;
  logic [31:0] gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle <= '0;
      gap  <= '1;
    end else begin
      idle <= dig_frame_ok ? '0 : idle + 16'(idle != '1);
      gap  <= (|underreach_zone && fault_forward) ? '0 : gap + 32'(gap != '1);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACTIVE: assert property ($past(presetn, 2) |->
    teleprot_active == &$past(nv_out.src_on)) else $error("active state wrong");
  AST_NO_REVERSE: assert property ($past(tx_a) == 3'h0 && !$past(fault_forward)
    |-> tx_a == 3'h0) else $error("send without forward fault");
  AST_PROLONG: assert property ($fell(|tx_a) && $past(teleprot_active)
    && !$past(chan_disturbed) |-> gap == 32'(PROLONG_DEFAULT_CYC + 1))
    else $error("send stretch length wrong");
  AST_OZ_SET: assert property (chan_disturbed && reclose_zone_release_input
    && $past(chan_disturbed) && $past(reclose_zone_release_input) |-> overreach_zone_enable)
    else $error("overreach zone not released");
  AST_OZ_IDLE: assert property (!chan_disturbed && !$past(chan_disturbed)
    |-> !overreach_zone_enable) else $error("overreach zone released without cause");
  AST_DISTURB: assert property ($rose(chan_disturbed) |-> $past(chan_fail)
    || idle >= DIG_TIMEOUT_CYC - 16'h2) else $error("disturbance without cause");
  AST_TRIP_RX: assert property (|trip |-> |{$past(rx_a), $past(rx_b)}
    && $past(teleprot_active)) else $error("trip without receive");
  AST_TRIP_CAUSE: assert property (|trip |-> |$past(pickup)
    || (|$past(overreach_zone) && $past(fault_forward))) else $error("trip without cause");
  AST_BLOCK: assert property ($past(chan_disturbed) |-> tx_a == 3'h0 && trip == 3'h0)
    else $error("supplement not blocked");
  AST_TX_B: assert property (tx_b == 3'h0 || tx_b == tx_a)
    else $error("second end send differs");
  COV_TRIP: cover property (|trip);
  COV_STRETCH: cover property ($fell(|tx_a));
  COV_OZ: cover property (overreach_zone_enable);
endmodule

bind utts_core utts_properties #(.PROLONG_DEFAULT_CYC(PROLONG_DEFAULT_CYC)) u_props (
  .pclk, .presetn, .nv_out, .underreach_zone, .overreach_zone, .pickup, .fault_forward,
  .rx_a, .rx_b, .chan_fail, .dig_frame_ok, .reclose_zone_release_input, .tx_a, .tx_b,
  .trip, .overreach_zone_enable, .chan_disturbed, .teleprot_active);

// ===== tb/utts_far_end.sv
// Far-end teleprotection model: one permissive channel back, plus frame pulses.
// Assumes the bench changes its fault flags just after a rising edge.
module utts_far_end #(parameter int DLY = 1) (
  input  logic       pclk,
  input  logic       frames_on,
  input  logic [2:0] far_fault,
  output logic [2:0] rx,
  output logic       frame_ok = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DLY:0][2:0] pipe = '0;
  logic [1:0]        div  = '0;
  assign rx = pipe[DLY];
  always @(posedge pclk) begin
    pipe     <= {pipe[DLY-1:0], far_fault};
    div      <= div + 2'h1;
    frame_ok <= frames_on && div == 2'h0;
  end
endmodule

// ===== tb/tb_top.sv
// Bench: register reads noted in a queue, scheme outputs compared in place.
// Assumes the core, its checker and the far-end model are compiled first.
module tb_top
  import utts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 20;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rnd = 32'h5835;
  logic        bin_switch = '1, nv_valid = '0, fault_forward = '0, chan_fail = '0;
  logic        reclose_zone_release_input = '0, frames_on = '1, dig_frame_ok;
  logic        overreach_zone_enable, chan_disturbed, teleprot_active;
  logic [2:0]  underreach_zone = '0, overreach_zone = '0, pickup = '0, far_a = '0, far_b = '0;
  logic [2:0]  rx_a, rx_b, tx_a, tx_b, trip;
  utts_nv_t    nv_in = NV_RST, nv_out;
  logic [32:0] exp_q[$];
  int          bad_count = 0, num_checks = 0, n;
  utts_core #(.PROLONG_DEFAULT_CYC(P)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bin_switch, .nv_valid, .nv_in, .nv_out,
    .underreach_zone, .overreach_zone, .pickup, .fault_forward, .rx_a, .rx_b, .chan_fail,
    .dig_frame_ok, .reclose_zone_release_input, .tx_a, .tx_b, .trip, .overreach_zone_enable,
    .chan_disturbed, .teleprot_active);
  utts_far_end #(.DLY(1)) u_far_a (.pclk, .frames_on, .far_fault(far_a), .rx(rx_a),
    .frame_ok(dig_frame_ok));
  utts_far_end #(.DLY(4)) u_far_b (.pclk, .frames_on, .far_fault(far_b), .rx(rx_b),
    .frame_ok());
  always #5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic chk(logic [32:0] seen, logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(int c);
    repeat (c) @(posedge pclk);
  endtask
  // Entered just after a rising edge; holds the request until pready is seen.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e = '0);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    // Let one edge pass so a following call never reassigns psel in this step.
    @(posedge pclk);
  endtask
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////
  initial begin
    wt(6);
    presetn <= 1'h1;
    wt(2);
    apb(0, ADDR_CFG, '0, 33'h3a0);
    apb(0, ADDR_PROLONG, '0, 33'h14);
    apb(0, ADDR_STATUS, '0, 33'hf);
    apb(0, 8'h10, '0, 33'h100000000);
    fault_forward <= 1'h1;
    underreach_zone <= 3'h2;
    wt(1);
    underreach_zone <= '0;
    wt(1);
    for (n = 0; tx_a === 3'h7; n++) @(posedge pclk);
    chk(33'(n), 33'(P + 1));
    fault_forward <= 1'h0;
    underreach_zone <= 3'h7;
    overreach_zone <= 3'h7;
    far_a <= 3'h1;
    wt(4);
    chk({tx_a, trip}, '0);
    pickup <= 3'h1;
    wt(4);
    chk(trip, 33'h7);
    $display("test pickup mode done");
    apb(1, ADDR_CFG, 32'h3a1);
    overreach_zone <= '0;
    underreach_zone <= '0;
    wt(4);
    chk(trip, '0);
    overreach_zone <= 3'h1;
    fault_forward <= 1'h1;
    wt(4);
    chk(trip, 33'h7);
    apb(1, ADDR_CFG, 32'h3e2);
    far_a <= '0;
    far_b <= 3'h1;
    underreach_zone <= 3'h2;
    wt(8);
    chk({tx_b, tx_a, trip}, 33'h1ff);
    apb(1, ADDR_CFG, 32'h3b4);
    wt(P + 4);
    chk({tx_b, tx_a}, 33'h12);
    frames_on <= 1'h0;
    reclose_zone_release_input <= 1'h1;
    wt(1100);
    chk({chan_disturbed, overreach_zone_enable, tx_a, trip}, 33'hc0);
    frames_on <= 1'h1;
    reclose_zone_release_input <= 1'h0;
    underreach_zone <= '0;
    wt(P + 10);
    apb(1, ADDR_CFG, 32'h3a0);
    chan_fail <= 1'h1;
    wt(3);
    chk(chan_disturbed, 33'h1);
    chan_fail <= 1'h0;
    $display("test link modes done");
    repeat (300) begin
      rnd = xs(rnd);
      {far_a, pickup, overreach_zone, underreach_zone, fault_forward} <= rnd[12:0];
      wt(1);
    end
    {far_a, far_b, underreach_zone} <= '0;
    wt(P + 10);
    apb(1, ADDR_SWCMD, 32'h8);
    apb(1, ADDR_SWCMD, 32'h1);
    wt(3);
    chk({teleprot_active, nv_out}, 33'h15);
    apb(1, ADDR_SWCMD, 32'h4);
    bin_switch <= 1'h0;
    wt(3);
    chk({teleprot_active, nv_out}, 33'h1b);
    bin_switch <= 1'h1;
    wt(3);
    chk(teleprot_active, 33'h1);
    $display("test switching done");
    print_verdict();
  end
endmodule
